/* ckst_consts.svh */
// Register offsets, field positions and reset values of the clock status block
`ifndef CKST_CONSTS_SVH
`define CKST_CONSTS_SVH
`define CKST_OFF_INTEN 8'h00
`define CKST_OFF_INTFLAG 8'h08
`define CKST_OFF_STATUS 8'h0C
`define CKST_OFF_OSCCTL 8'h10
`define CKST_OSCCTL_RST 16'h0080
`define CKST_OSCCTL_MASK 16'hFFC6
`define CKST_B_ENABLE 1
`define CKST_B_XTAL 2
`define CKST_B_STBY 6
`define CKST_B_ONDEM 7
`define CKST_GAIN_LSB 8
`define CKST_GAIN_MSB 10
`define CKST_B_AUTO_AMPLITUDE_CONTROL 11
`define CKST_SU_LSB 12
`define CKST_SU_MSB 15
`define CKST_B_LTO 17
`define CKST_B_LFALL 16
`define CKST_B_LRISE 15
`define CKST_B_BSYNC 11
`define CKST_B_BDET 10
`define CKST_B_BRDY 9
`define CKST_B_RCS 8
`define CKST_B_LCKC 7
`define CKST_B_LCKF 6
`define CKST_B_OOB 5
`define CKST_B_FRDY 4
`define CKST_B_R8M 3
`define CKST_B_R32K 2
`define CKST_B_X32K 1
`define CKST_B_XRDY 0
`define CKST_NFLAG 18
`define CKST_SYNC_CYC 2'h3
`define CKST_CNT_ONE 16'h0001
`define CKST_HTRANS_NONSEQ 2'h2
`endif

/* ckst_pkg.sv */
// Types shared by the clock status block modules
package ckst_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_SYNC, ST_READY} ckst_su_t;
  typedef struct packed {
    ckst_su_t st;
    logic ulp_prev;
    logic oscillator_control_prev;
    logic [15:0] cnt;
    logic [1:0] sync;
    logic ready;
  } ckst_start_t;
  typedef struct packed {
    logic [17:0] prev;
    logic [17:0] flag;
    logic irq;
  } ckst_flag_t;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [15:0] ctrl;
    logic [17:0] inten;
    logic [2:0] gain;
    logic run;
    logic lock_prev;
    logic lfall;
    logic lrise;
    logic [31:0] status;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } ckst_main_t;
endpackage : ckst_pkg

/* ckst_flags.sv */
// Sticky edge flags on status bits with write-one-to-clear and request output
`timescale 1ns/1ps
`include "ckst_consts.svh"
module ckst_flags (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Status, enables and clears
  input wire logic [17:0] status,
  input wire logic [17:0] enable,
  input wire logic [17:0] clear,
  // Results
  output logic [17:0] flag_q,
  output logic irq_q
);
  ckst_pkg::ckst_flag_t s_q, s_d;
  logic [17:0] flag_n;

  // Per-bit rising edge sets, software one clears, set wins
  genvar i;
  generate
    for (i = 0; i < `CKST_NFLAG; i++) begin : g_flag
      assign flag_n[i] = (status[i] & ~s_q.prev[i]) |
                         (s_q.flag[i] & ~clear[i]); // RULE_16
    end
  endgenerate

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.prev = status;
    s_d.flag = flag_n;
    s_d.irq = |(flag_n & enable); // RULE_16
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_q = s_q.flag;
  assign irq_q = s_q.irq;
endmodule : ckst_flags

/* ckst_delay_select_a.sv */
// Crystal oscillator start-up counter and ready synchronisation
`timescale 1ns/1ps
`include "ckst_consts.svh"
module ckst_delay_select_a (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic [3:0] delay_sel,
  // Oscillator levels sampled on hclk
  input wire logic ulp_clk,
  input wire logic oscillator_control_clk,
  // Ready
  output logic ready_q
);
  ckst_pkg::ckst_start_t s_q, s_d;

  // Count slow ticks, then crystal ticks, then flag ready
  always_comb begin
    s_d = s_q;
    s_d.ulp_prev = ulp_clk;
    s_d.oscillator_control_prev = oscillator_control_clk;
    if (!run) begin
      s_d.st = ckst_pkg::ST_IDLE;
      s_d.ready = 1'b0;
    end else begin
      unique case (s_q.st)
        ckst_pkg::ST_IDLE: begin
          s_d.cnt = `CKST_CNT_ONE << delay_sel; // RULE_14
          s_d.st = ckst_pkg::ST_COUNT;
        end
        ckst_pkg::ST_COUNT: begin
          if (ulp_clk && !s_q.ulp_prev) begin // RULE_13
            if (s_q.cnt == `CKST_CNT_ONE) begin
              s_d.sync = `CKST_SYNC_CYC;
              s_d.st = ckst_pkg::ST_SYNC;
            end else begin
              s_d.cnt = s_q.cnt - `CKST_CNT_ONE;
            end
          end
        end
        ckst_pkg::ST_SYNC: begin
          if (oscillator_control_clk && !s_q.oscillator_control_prev) begin // RULE_15
            if (s_q.sync == 2'h1) begin
              s_d.ready = 1'b1;
              s_d.st = ckst_pkg::ST_READY;
            end else begin
              s_d.sync = s_q.sync - 2'h1;
            end
          end
        end
        ckst_pkg::ST_READY: begin
          s_d.ready = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ready_q = s_q.ready;
endmodule : ckst_delay_select_a

/* ckst_top.sv */
// Clock status register, oscillator control and AHB-Lite register slave
`timescale 1ns/1ps
`include "ckst_consts.svh"

// Behaviour
// RULE_01 - Status bit 17 shows the phase-locked loop lock time-out.
// RULE_02 - Status bit 16 shows a detected falling edge of loop lock.
// RULE_03 - Status bit 15 shows a detected rising edge of loop lock.
// RULE_04 - Status bit 11 is one while brown-out register sync is ongoing.
// RULE_05 - Status bit 10 is one when the I/O supply is below reference.
// RULE_06 - Status bit 9 is one when the brown-out detector is ready.
// RULE_07 - Status bit 8 is one when the FLL reference clock stopped.
// RULE_08 - Status bit 7 is one on FLL coarse lock.
// RULE_09 - Status bit 6 is one on FLL fine lock.
// RULE_10 - Status bit 5 is one when the FLL is out of bounds.
// RULE_11 - Status bit 4 is one once FLL register sync is complete.
// RULE_12 - Bits 3 to 0 show the four oscillators stable and usable.
// RULE_13 - Start-up field 15:12 picks the delay, counted on slow oscillator.
// RULE_14 - Start-up count is two to the power of the field value.
// RULE_15 - Three crystal cycles of sync follow before ready is set.
// RULE_16 - Flags set on status rising edge, request when enabled, one clears.
// RULE_17 - Software enables gain control after ready; gain field then ignored.
// RULE_18 - On-demand runs the oscillator only while a clock is requested.
// RULE_19 - In standby the oscillator stops unless run-in-standby is set.
// RULE_20 - The status register is read-only; writes change nothing.
module ckst_top (
  // AHB-Lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // AHB-Lite data phase
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Phase-locked loop indications
  input wire logic pll_lock_timeout,
  input wire logic pll_lock,
  // Brown-out detector indications
  input wire logic brownout_sync_busy,
  input wire logic brownout_detected,
  input wire logic brownout_ready,
  // Frequency-locked loop indications
  input wire logic fll_ref_clock_stopped,
  input wire logic fll_coarse_lock,
  input wire logic fll_fine_lock,
  input wire logic fll_out_of_bounds,
  input wire logic fll_sync_ready,
  // Other oscillator ready levels
  input wire logic internal_8m_ready,
  input wire logic internal_32k_ready,
  input wire logic crystal_32k_ready,
  // Oscillator clocks and system state
  input wire logic ultra_low_power_32k_osc,
  input wire logic crystal_osc_clk,
  input wire logic standby_mode,
  input wire logic clock_request,
  // Oscillator pad and analog controls
  output logic osc_run,
  output logic crystal_select,
  output logic auto_amplitude_control,
  output logic [2:0] osc_gain,
  // Flag request and ready
  output logic irq_request,
  output logic crystal_osc_ready
);
  ckst_pkg::ckst_main_t s_q, s_d;
  logic [17:0] flag_clear;
  logic [17:0] flag_val;
  logic irq_val;
  logic ready_val;

  // Match a latched or live byte address against a register offset
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction : addr_hit

  // Read multiplexer over the register map; unmapped reads give zero
  function automatic logic [31:0] read_mux(input logic [7:0] a,
                                           input logic [17:0] en,
                                           input logic [17:0] fl,
                                           input logic [31:0] st,
                                           input logic [15:0] ct);
    read_mux = 32'h0000_0000;
    if (addr_hit(a, `CKST_OFF_INTEN)) begin
      read_mux = {14'h0000, en};
    end else if (addr_hit(a, `CKST_OFF_INTFLAG)) begin
      read_mux = {14'h0000, fl};
    end else if (addr_hit(a, `CKST_OFF_STATUS)) begin
      read_mux = st;
    end else if (addr_hit(a, `CKST_OFF_OSCCTL)) begin
      read_mux = {16'h0000, ct};
    end
  endfunction : read_mux

  // Sticky interrupt flags on the status bits
  ckst_flags u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .status(s_q.status[17:0]),
    .enable(s_q.inten),
    .clear(flag_clear),
    .flag_q(flag_val),
    .irq_q(irq_val)
  );

  // Start-up counter of the crystal oscillator
  ckst_delay_select_a u_delay_select_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(s_q.run),
    .delay_sel(s_q.ctrl[`CKST_SU_MSB:`CKST_SU_LSB]), // RULE_13
    .ulp_clk(ultra_low_power_32k_osc),
    .oscillator_control_clk(crystal_osc_clk),
    .ready_q(ready_val)
  );

  // Bus decode, register writes, status capture and oscillator control
  always_comb begin
    s_d = s_q;
    flag_clear = '0;
    s_d.hready = 1'b1;
    s_d.hresp = 1'b0;

    // Data phase of a pending write
    s_d.wr = 1'b0;
    if (s_q.wr) begin
      if (addr_hit(s_q.addr, `CKST_OFF_INTEN)) begin
        s_d.inten = hwdata[17:0];
      end
      if (addr_hit(s_q.addr, `CKST_OFF_INTFLAG)) begin
        flag_clear = hwdata[17:0]; // RULE_16
      end
      if (addr_hit(s_q.addr, `CKST_OFF_OSCCTL)) begin
        s_d.ctrl = hwdata[15:0] & `CKST_OSCCTL_MASK;
      end
      // A write to the status offset is dropped here   // RULE_20
    end

    // Lock edge capture; each edge bit clears on the opposite edge
    s_d.lock_prev = pll_lock;
    if (!pll_lock && s_q.lock_prev) begin
      s_d.lfall = 1'b1; // RULE_02
      s_d.lrise = 1'b0;
    end else if (pll_lock && !s_q.lock_prev) begin
      s_d.lrise = 1'b1; // RULE_03
      s_d.lfall = 1'b0;
    end

    // Status word assembled from live indications, captured lock edges and start-up ready
    s_d.status = 32'h0000_0000;
    s_d.status[`CKST_B_LTO] = pll_lock_timeout; // RULE_01
    s_d.status[`CKST_B_LFALL] = s_q.lfall; // RULE_02
    s_d.status[`CKST_B_LRISE] = s_q.lrise; // RULE_03
    s_d.status[`CKST_B_BSYNC] = brownout_sync_busy; // RULE_04
    s_d.status[`CKST_B_BDET] = brownout_detected; // RULE_05
    s_d.status[`CKST_B_BRDY] = brownout_ready; // RULE_06
    s_d.status[`CKST_B_RCS] = fll_ref_clock_stopped; // RULE_07
    s_d.status[`CKST_B_LCKC] = fll_coarse_lock; // RULE_08
    s_d.status[`CKST_B_LCKF] = fll_fine_lock; // RULE_09
    s_d.status[`CKST_B_OOB] = fll_out_of_bounds; // RULE_10
    s_d.status[`CKST_B_FRDY] = fll_sync_ready; // RULE_11
    s_d.status[`CKST_B_R8M] = internal_8m_ready; // RULE_12
    s_d.status[`CKST_B_R32K] = internal_32k_ready; // RULE_12
    s_d.status[`CKST_B_X32K] = crystal_32k_ready; // RULE_12
    s_d.status[`CKST_B_XRDY] = ready_val; // RULE_12

    // Oscillator run decision from enable, on-demand and standby
    s_d.run = s_d.ctrl[`CKST_B_ENABLE] &
              (~s_d.ctrl[`CKST_B_ONDEM] | clock_request) & // RULE_18
              (~standby_mode | s_d.ctrl[`CKST_B_STBY]); // RULE_19

    // Gain reaches the pad only while automatic control is off
    if (!s_d.ctrl[`CKST_B_AUTO_AMPLITUDE_CONTROL]) begin
      s_d.gain = s_d.ctrl[`CKST_GAIN_MSB:`CKST_GAIN_LSB]; // RULE_17
    end

    // Address phase: latch the transfer, prepare read data
    if (hsel && hready && htrans == `CKST_HTRANS_NONSEQ) begin
      s_d.addr = haddr[7:0];
      s_d.wr = hwrite;
      if (!hwrite) begin
        s_d.hrdata = read_mux(haddr[7:0], s_d.inten, flag_val,
                              s_q.status, s_d.ctrl);
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ctrl <= `CKST_OSCCTL_RST;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register, irq_request and crystal_osc_ready from the flag and start-up registers
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hready;
  assign hresp = s_q.hresp;
  assign osc_run = s_q.run;
  assign crystal_select = s_q.ctrl[`CKST_B_XTAL];
  assign auto_amplitude_control = s_q.ctrl[`CKST_B_AUTO_AMPLITUDE_CONTROL]; // RULE_17
  assign osc_gain = s_q.gain;
  assign irq_request = irq_val; // RULE_16
  assign crystal_osc_ready = ready_val;
endmodule : ckst_top

/* ckst_checker.sv */
// Port assertions for the clock status block
`timescale 1ns/1ps
module ckst_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Oscillator
  input wire logic crystal_osc_clk,
  input wire logic osc_run,
  input wire logic auto_amplitude_control,
  input wire logic [2:0] osc_gain,
  input wire logic crystal_osc_ready
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_q;
  // Read address phase taken at the last edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= hsel && hready && htrans == 2'h2 && !hwrite;
    end
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  a_ready_drop: assert property (!osc_run |=> !crystal_osc_ready)
    else $error("ready kept after stop");
  a_ready_edge: assert property ($rose(crystal_osc_ready) |->
    $past(crystal_osc_clk) && !$past(crystal_osc_clk, 2))
    else $error("ready not on a crystal rise");
  a_start_min: assert property ($rose(crystal_osc_ready) |->
    $past(osc_run, 6))
    else $error("ready too soon after start");
  a_ready_hold: assert property (crystal_osc_ready && osc_run |=>
    crystal_osc_ready)
    else $error("ready lost while running");
  a_gain_frozen: assert property (auto_amplitude_control &&
    $past(auto_amplitude_control) |-> $stable(osc_gain))
    else $error("gain moved under auto control");
endmodule : ckst_checker

bind ckst_top ckst_checker u_chk (.hclk, .hresetn, .hsel, .hready, .htrans,
  .hwrite, .hrdata, .hreadyout, .hresp, .crystal_osc_clk, .osc_run,
  .auto_amplitude_control, .osc_gain, .crystal_osc_ready);

/* ckst_osc_model.sv */
// Slow oscillator and crystal clock source for the start-up logic
`timescale 1ns/1ps
module ckst_osc_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Run request from the block
  input wire logic osc_run,
  // Clock levels
  output logic ulp_osc,
  output logic oscillator_control_clk
);
  logic [3:0] div_q;
  // Slow clock runs free; crystal stands at zero while stopped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 4'h0;
      ulp_osc <= 1'b0;
      oscillator_control_clk <= 1'b0;
    end else begin
      div_q <= div_q + 4'h1;
      if (div_q == 4'hF) ulp_osc <= ~ulp_osc;
      oscillator_control_clk <= osc_run & ~oscillator_control_clk;
    end
  end
endmodule : ckst_osc_model

/* test_clock_status_and_oscillator_control_delay_select_a.sv */
// Self-checking bench for the clock status block
`timescale 1ns/1ps
module test_clock_status_and_oscillator_control_delay_select_a;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic pll_to = 1'b0, pll_lock = 1'b0, stby = 1'b0, creq = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [10:0] lv = 11'h000;
  logic [31:0] hrdata, rd;
  logic [2:0] gain;
  logic hreadyout, hresp, ulp, xclk, osc_run, xsel, aac, irq, rdy;
  logic on_q = 1'b0, ulp_p = 1'b0, x_p = 1'b0;
  int err_count = 0, total_checks = 0, ur = 0, xr = 0;

  // Clock
  always #2.5 hclk = ~hclk;

  ckst_top u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .pll_lock_timeout(pll_to), .pll_lock,
    .brownout_sync_busy(lv[10]), .brownout_detected(lv[9]),
    .brownout_ready(lv[8]), .fll_ref_clock_stopped(lv[7]),
    .fll_coarse_lock(lv[6]), .fll_fine_lock(lv[5]),
    .fll_out_of_bounds(lv[4]), .fll_sync_ready(lv[3]),
    .internal_8m_ready(lv[2]), .internal_32k_ready(lv[1]),
    .crystal_32k_ready(lv[0]), .ultra_low_power_32k_osc(ulp),
    .crystal_osc_clk(xclk), .standby_mode(stby), .clock_request(creq),
    .osc_run, .crystal_select(xsel), .auto_amplitude_control(aac),
    .osc_gain(gain), .irq_request(irq), .crystal_osc_ready(rdy));

  ckst_osc_model u_osc (.hclk, .hresetn, .osc_run, .ulp_osc(ulp),
    .oscillator_control_clk(xclk));

  // Count slow and crystal rises while the oscillator runs
  always @(posedge hclk) begin
    on_q <= osc_run;
    ulp_p <= ulp;
    x_p <= xclk;
    if (!on_q) begin
      ur <= 0; // Counts restart whenever the oscillator is stopped
      xr <= 0;
    end else if (ulp && !ulp_p) begin
      ur <= ur + 1;
      xr <= 0;
    end else if (xclk && !x_p) begin
      xr <= xr + 1;
    end
  end

  task chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task t_regs;
    rdc(8'h10, 32'h0080);
    ahb(1'b1, 8'h10, 32'hFFFF_F7FD);
    @(negedge hclk);
    chk(gain, 32'h7);
    chk(xsel, 32'h1);
    rdc(8'h10, 32'h0000_F7C4);
    ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rdc(8'h0C, 32'h0);
    rdc(8'h3C, 32'h0);
    ahb(1'b1, 8'h10, 32'h0080);
  endtask : t_regs

  task t_status;
    for (int i = 0; i < 11; i++) begin
      @(posedge hclk);
      lv <= 11'h001 << i;
      rdc(8'h0C, 32'h2 << i);
    end
    @(posedge hclk);
    lv <= 11'h000;
    pll_lock <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc(8'h0C, 32'h0000_8000);
    pll_lock <= 1'b0;
    repeat (3) @(posedge hclk);
    rdc(8'h0C, 32'h0001_0000);
    pll_to <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc(8'h0C, 32'h0003_0000);
    pll_to <= 1'b0;
  endtask : t_status

  task t_flags;
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h08, 32'h0003_FFFF);
    rdc(8'h08, 32'h0);
    lv <= 11'h001;
    repeat (3) @(posedge hclk);
    rdc(8'h08, 32'h2);
    chk(irq, 32'h0);
    ahb(1'b1, 8'h00, 32'h2);
    repeat (2) @(posedge hclk);
    chk(irq, 32'h1);
    rdc(8'h00, 32'h2);
    ahb(1'b1, 8'h08, 32'h0);
    rdc(8'h08, 32'h2);
    ahb(1'b1, 8'h08, 32'h2);
    rdc(8'h08, 32'h0);
    chk(irq, 32'h0);
  endtask : t_flags

  task t_start(input logic [3:0] su);
    ahb(1'b1, 8'h10, {16'h0, su, 12'h002});
    while (rdy !== 1'b1) @(posedge hclk);
    chk(ur, 32'h1 << su);
    chk(xr, 32'h3);
    rdc(8'h0C, 32'h0001_0003);
    ahb(1'b1, 8'h10, {16'h0, su, 12'hD02});
    repeat (2) @(posedge hclk);
    chk({aac, gain}, 32'h8);
    ahb(1'b1, 8'h10, 32'h0080);
    repeat (2) @(posedge hclk);
    chk(rdy, 32'h0);
  endtask : t_start

  // Run level against request, standby and keep-running control
  task t_modes;
    creq <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(osc_run, 32'h0);
    ahb(1'b1, 8'h10, 32'h0082);
    repeat (2) @(posedge hclk);
    chk(osc_run, 32'h1);
    stby <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(osc_run, 32'h0);
    ahb(1'b1, 8'h10, 32'h00C2);
    repeat (2) @(posedge hclk);
    chk(osc_run, 32'h1);
    creq <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(osc_run, 32'h0);
    ahb(1'b1, 8'h10, 32'h0042);
    repeat (2) @(posedge hclk);
    chk(osc_run, 32'h1);
  endtask : t_modes

  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_status();
    t_flags();
    t_start(4'h0);
    t_start(4'h3);
    t_modes();
    finish_test();
  end

  // Watchdog
  initial begin
    #50000;
    err_count++;
    finish_test();
  end
endmodule : test_clock_status_and_oscillator_control_delay_select_a
